// ===== verilog/srrse_exec.sv
// Purpose: Executes rotate, subtract, return and sleep on a small core state, APB slave
// Assumes: Instructions are issued by writing the instruction register
// Notes:   An instruction write while a return is in flight waits with pready low
`timescale 1ns/100ps
module srrse_exec
  import srrse_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core state views
  output logic      [14:0] pc_out,
  output logic             power_down_flag_n,
  output logic             watchdog_expiry_flag_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  srrse_alu_if alu_bus ();

  logic [7:0]      file_mem [FILE_DEPTH];
  logic [14:0]     stack_mem [STACK_DEPTH];
  logic [3:0]      sp_r;
  logic [4:0]      depth_r;
  logic [7:0]      acc_r;
  logic            carry_r;
  logic            nibble_carry_r;
  logic            zero_r;
  logic            power_down_flag_n_r;
  logic            watchdog_expiry_flag_n_r;
  logic [14:0]     pc_r;
  logic [14:0]     stack_head_r;
  logic [7:0]      watchdog_counter_r;
  logic [7:0]      prescaler_r;
  logic [31:0]     prdata_r;
  srrse_state_t    state_r;

  logic            access;
  logic            wr_en;
  logic            rd_en;
  logic            instr_hit;
  logic            file_hit;
  logic            mapped;
  logic            issue;
  srrse_op_t       op;
  logic            dest_file;
  logic [6:0]      faddr;
  logic [7:0]      literal;
  logic [6:0]      bus_faddr;
  logic [7:0]      file_src;
  logic            is_sub;
  logic            is_file_op;
  logic [3:0]      sp_top;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  assign access    = psel & penable;
  assign file_hit  = (paddr >= OFS_FILE_BASE) && (paddr <= OFS_FILE_LAST) && (paddr[1:0] == 2'b00);
  assign instr_hit = reg_hit(paddr, OFS_INSTR);
  assign mapped    = file_hit | instr_hit | reg_hit(paddr, OFS_ACC) | reg_hit(paddr, OFS_STATUS) |
                     reg_hit(paddr, OFS_PC) | reg_hit(paddr, OFS_STACK) | reg_hit(paddr, OFS_WDOG) |
                     reg_hit(paddr, OFS_BUSY);
  // Instruction writes stall while a return is still in its second cycle
  assign pready    = ~(access & pwrite & instr_hit & (state_r != SRRSE_IDLE));
  assign pslverr   = access & ~mapped;
  assign wr_en     = access & pready & pwrite & mapped & pstrb[0];
  assign rd_en     = access & pready & ~pwrite;
  assign bus_faddr = paddr[8:2];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction issue and operand fetch

  assign issue     = wr_en & instr_hit;
  assign op        = srrse_op_t'(pwdata[INSTR_OP_LSB +: 3]);
  assign dest_file = pwdata[INSTR_DEST_BIT];
  assign faddr     = pwdata[INSTR_FA_LSB +: 7];
  assign literal   = pwdata[INSTR_LIT_LSB +: 8];
  assign is_sub    = (op == SRRSE_OP_SUBF) || (op == SRRSE_OP_SUBFB) || (op == SRRSE_OP_SUBLIT);
  assign is_file_op = (op == SRRSE_OP_RRC) || (op == SRRSE_OP_SUBF) || (op == SRRSE_OP_SUBFB);
  assign sp_top    = sp_r - 4'h1;

  // [RL3] Full file register read
  assign file_src  = file_mem[faddr];

  assign alu_bus.op       = op;
  // [RL11] Literal as minuend
  assign alu_bus.src      = (op == SRRSE_OP_SUBLIT) ? literal : file_src;
  assign alu_bus.acc      = acc_r;
  assign alu_bus.carry_in = carry_r;

  srrse_alu u_alu (
    .a (alu_bus.alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= ACC_RST;
    end else if (issue && op == SRRSE_OP_SUBLIT) begin
      // [RL11] Always into accumulator
      acc_r <= alu_bus.result;
    end else if (issue && is_file_op && !dest_file) begin
      // [RL2] Destination accumulator
      acc_r <= alu_bus.result;
    end else if (wr_en && reg_hit(paddr, OFS_ACC)) begin
      acc_r <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File registers

  always_ff @(posedge pclk) begin
    if (issue && is_file_op && dest_file) begin
      // [RL2] Destination file register
      file_mem[faddr] <= alu_bus.result;
    end else if (wr_en && file_hit) begin
      file_mem[bus_faddr] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic flags

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_r        <= 1'b0;
      nibble_carry_r <= 1'b0;
      zero_r         <= 1'b0;
    end else if (issue && op == SRRSE_OP_RRC) begin
      // [RL1] Only carry updated
      carry_r <= alu_bus.carry_out;
    end else if (issue && is_sub) begin
      // [RL12] Carry means no borrow
      carry_r        <= alu_bus.carry_out;
      nibble_carry_r <= alu_bus.nibble_out;
      // [RL13] Zero flag update
      zero_r         <= alu_bus.zero_out;
    end else if (wr_en && reg_hit(paddr, OFS_STATUS)) begin
      carry_r        <= pwdata[ST_CARRY];
      nibble_carry_r <= pwdata[ST_NIBBLE];
      zero_r         <= pwdata[ST_ZERO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return sequencer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SRRSE_IDLE;
    end else begin
      unique case (state_r)
        SRRSE_IDLE: begin
          // [RL5] First of two cycles
          if (issue && op == SRRSE_OP_RETURN) begin
            state_r <= SRRSE_RET2;
          end
        end
        SRRSE_RET2: begin
          state_r <= SRRSE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware stack

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r         <= 4'h0;
      depth_r      <= 5'h00;
      stack_head_r <= PC_RST;
    end else if (issue && op == SRRSE_OP_RETURN) begin
      // [RL4] Pop the stack
      stack_head_r <= stack_mem[sp_top];
      sp_r         <= sp_top;
      if (depth_r != 5'h00) begin
        depth_r <= depth_r - 5'h01;
      end
    end else if (issue && op == SRRSE_OP_PUSH) begin
      sp_r <= sp_r + 4'h1;
      if (depth_r != 5'h10) begin
        depth_r <= depth_r + 5'h01;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (issue && op == SRRSE_OP_PUSH) begin
      stack_mem[sp_r] <= pc_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= PC_RST;
    end else if (state_r == SRRSE_RET2) begin
      // [RL5] Second cycle loads target
      pc_r <= stack_head_r;
    end else if (issue && op != SRRSE_OP_RETURN) begin
      pc_r <= pc_r + 15'h0001;
    end else if (wr_en && reg_hit(paddr, OFS_PC)) begin
      pc_r <= pwdata[14:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter and prescaler

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescaler_r        <= PRESC_CLR;
      watchdog_counter_r <= WDOG_CLR;
    end else if (issue && op == SRRSE_OP_SLEEP) begin
      // [RL8] Clear counter and prescaler
      prescaler_r        <= PRESC_CLR;
      watchdog_counter_r <= WDOG_CLR;
    end else begin
      prescaler_r <= prescaler_r + 8'h01;
      if (prescaler_r == PRESC_LAST) begin
        watchdog_counter_r <= watchdog_counter_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down and watchdog-expiry flags

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag_n_r      <= 1'b1;
      watchdog_expiry_flag_n_r <= 1'b1;
    end else if (issue && op == SRRSE_OP_SLEEP) begin
      // [RL6] Power-down flag cleared
      power_down_flag_n_r      <= 1'b0;
      // [RL7] Expiry flag set
      watchdog_expiry_flag_n_r <= 1'b1;
    end else if (prescaler_r == PRESC_LAST && watchdog_counter_r == 8'hff) begin
      watchdog_expiry_flag_n_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= 32'h0000_0000;
      if (file_hit) begin
        prdata_r <= {24'h000000, file_mem[bus_faddr]};
      end else begin
        unique case (paddr)
          OFS_ACC:    prdata_r <= {24'h000000, acc_r};
          OFS_STATUS: prdata_r <= {27'h0000000, watchdog_expiry_flag_n_r, power_down_flag_n_r,
                                   zero_r, nibble_carry_r, carry_r};
          OFS_PC:     prdata_r <= {17'h00000, pc_r};
          OFS_STACK:  prdata_r <= {11'h000, depth_r, 1'b0, stack_head_r};
          OFS_WDOG:   prdata_r <= {16'h0000, prescaler_r, watchdog_counter_r};
          OFS_BUSY:   prdata_r <= {31'h00000000, state_r != SRRSE_IDLE};
          default:    prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata                 = rd_en ? prdata_r : 32'h0000_0000;
  assign pc_out                 = pc_r;
  assign power_down_flag_n      = power_down_flag_n_r;
  assign watchdog_expiry_flag_n = watchdog_expiry_flag_n_r;

endmodule // srrse_exec

// ===== verilog/srrse_pkg.sv
// Purpose: Constants and types for the subtract, rotate, return and sleep execution block
// Assumes: 32-bit APB, one word per register, pclk at 250 MHz
// Notes:   Summary of operation follows
//
// Summary of operation
// [RL1] Rotate right through carry, only carry changes
// [RL2] Destination bit: 0 accumulator, 1 file
// [RL3] Rotate reads full file register as source
// [RL4] Return pops stack into PC, flags kept
// [RL5] Return takes two instruction cycles
// [RL6] Sleep clears power-down flag to zero
// [RL7] Sleep sets watchdog-expiry flag to one
// [RL8] Sleep clears watchdog counter and prescaler
// [RL9] File minus accumulator, flags C DC Z
// [RL10] File minus accumulator minus inverted carry
// [RL11] Literal minus accumulator, always to accumulator
// [RL12] Carry and nibble carry set on no borrow
// [RL13] Zero flag set when result is zero
package srrse_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_INSTR     = 12'h000;
  localparam logic [11:0] OFS_ACC       = 12'h004;
  localparam logic [11:0] OFS_STATUS    = 12'h008;
  localparam logic [11:0] OFS_PC        = 12'h00c;
  localparam logic [11:0] OFS_STACK     = 12'h010;
  localparam logic [11:0] OFS_WDOG      = 12'h014;
  localparam logic [11:0] OFS_BUSY      = 12'h018;
  localparam logic [11:0] OFS_FILE_BASE = 12'h200;
  localparam logic [11:0] OFS_FILE_LAST = 12'h3fc;

  // Instruction word fields
  localparam int INSTR_OP_LSB   = 0;
  localparam int INSTR_DEST_BIT = 3;
  localparam int INSTR_FA_LSB   = 4;
  localparam int INSTR_LIT_LSB  = 16;

  // Status fields
  localparam int ST_CARRY  = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO   = 2;
  localparam int ST_PD_N   = 3;
  localparam int ST_TO_N   = 4;

  // Sizes and reset values
  localparam int          FILE_DEPTH  = 128;
  localparam int          STACK_DEPTH = 16;
  localparam int          PC_W        = 15;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [14:0] PC_RST      = 15'h0000;
  localparam logic [7:0]  WDOG_CLR    = 8'h00;
  localparam logic [7:0]  PRESC_CLR   = 8'h00;
  localparam logic [7:0]  PRESC_LAST  = 8'hff;

  typedef enum logic [2:0] {
    SRRSE_OP_NOP     = 3'h0,
    SRRSE_OP_RRC     = 3'h1,
    SRRSE_OP_SUBF    = 3'h2,
    SRRSE_OP_SUBFB   = 3'h3,
    SRRSE_OP_SUBLIT  = 3'h4,
    SRRSE_OP_RETURN  = 3'h5,
    SRRSE_OP_SLEEP   = 3'h6,
    SRRSE_OP_PUSH    = 3'h7
  } srrse_op_t;

  typedef enum logic {
    SRRSE_IDLE,
    SRRSE_RET2
  } srrse_state_t;

endpackage

// ===== verilog/srrse_alu_if.sv
// Purpose: Carries operands and results between the executor and its arithmetic unit
// Assumes: Combinational unit, one operation per cycle
// Notes:   Carry in is the status carry as stored
`timescale 1ns/100ps
interface srrse_alu_if;
  import srrse_pkg::*;
  srrse_op_t  op;
  logic [7:0] src;
  logic [7:0] acc;
  logic       carry_in;
  logic [7:0] result;
  logic       carry_out;
  logic       nibble_out;
  logic       zero_out;

  modport exec (output op, src, acc, carry_in, input result, carry_out, nibble_out, zero_out);
  modport alu  (input op, src, acc, carry_in, output result, carry_out, nibble_out, zero_out);
endinterface

// ===== verilog/srrse_alu.sv
// Purpose: Rotate and subtract arithmetic
// Assumes: Operands settled within one pclk cycle
// Notes:   Subtract is addition of the inverted accumulator plus a carry in
`timescale 1ns/100ps
module srrse_alu
  import srrse_pkg::*;
(
  // Operand and result bundle
  srrse_alu_if.alu a
);

  logic       sub_cin;
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  always_comb begin
    // [RL10] Borrow from carry
    sub_cin = (a.op == SRRSE_OP_SUBFB) ? a.carry_in : 1'b1;
  end

  // [RL9] Two's complement subtract
  assign full_sum = {1'b0, a.src} + {1'b0, ~a.acc} + {8'h00, sub_cin};
  assign low_sum  = {1'b0, a.src[3:0]} + {1'b0, ~a.acc[3:0]} + {4'h0, sub_cin};

  always_comb begin
    a.result     = full_sum[7:0];
    a.carry_out  = full_sum[8];
    a.nibble_out = low_sum[4];
    if (a.op == SRRSE_OP_RRC) begin
      // [RL1] Old carry enters top bit
      a.result    = {a.carry_in, a.src[7:1]};
      a.carry_out = a.src[0];
    end
  end

  // [RL13] Zero on result
  assign a.zero_out = (full_sum[7:0] == 8'h00);

endmodule // srrse_alu

// ===== sim/srrse_exec_assertions.sv
// Purpose: Concurrent checks on the execution block ports
// Assumes: APB master holds each request until pready
// Notes:   Bound to every srrse_exec instance
`timescale 1ns/100ps
module srrse_exec_assertions
  import srrse_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core state views
  input wire logic [14:0] pc_out,
  input wire logic        power_down_flag_n,
  input wire logic        watchdog_expiry_flag_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc_ph;
  logic ins_wr;
  logic sleep_wr;
  logic ret_wr;
  assign acc_ph   = psel && penable;
  assign ins_wr   = acc_ph && pready && pwrite && pstrb[0] && (paddr == OFS_INSTR);
  assign sleep_wr = ins_wr && (pwdata[2:0] == SRRSE_OP_SLEEP);
  assign ret_wr   = ins_wr && (pwdata[2:0] == SRRSE_OP_RETURN);
  //////////////////////////////////////////////////////////////////////////////
  AST_SLEEP_PD: assert property (
    sleep_wr |=> !power_down_flag_n) else $error("sleep left power-down flag high");
  AST_PD_CAUSE: assert property (
    $fell(power_down_flag_n) |-> $past(sleep_wr)) else $error("power-down flag fell without sleep");
  AST_SLEEP_TO: assert property (
    sleep_wr |=> watchdog_expiry_flag_n) else $error("sleep left expiry flag low");
  AST_TO_CAUSE: assert property (
    $rose(watchdog_expiry_flag_n) |-> $past(sleep_wr)) else $error("expiry flag rose without sleep");
  AST_SLEEP_WDOG: assert property (
    sleep_wr ##3 (acc_ph && !pwrite && paddr == OFS_WDOG) |-> prdata[7:0] == 8'h00 && prdata[15:8] <= 8'h03)
    else $error("watchdog not cleared by sleep");
  AST_RET_HOLD: assert property (
    ret_wr |=> $stable(pc_out)) else $error("return loaded pc in its first cycle");
  AST_RET_FLAGS: assert property (
    ret_wr |=> $stable(power_down_flag_n) && $stable(watchdog_expiry_flag_n)) else $error("return moved flags");
  AST_PREADY: assert property (
    !pready |-> acc_ph && pwrite && paddr == OFS_INSTR) else $error("wait state outside instruction write");
endmodule // srrse_exec_assertions

bind srrse_exec srrse_exec_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pc_out(pc_out), .power_down_flag_n(power_down_flag_n),
  .watchdog_expiry_flag_n(watchdog_expiry_flag_n));

// ===== sim/subtract_rotate_return_sleep_exec_test.sv
// Purpose: Self-checking bench for the execution block
// Assumes: APB master with bounded waits
// Notes:   Table of operations, then return, sleep and reset cases
`timescale 1ns/100ps
module subtract_rotate_return_sleep_exec_test;
  import srrse_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic       d;
    logic [6:0] fa;
    logic [7:0] fv;
    logic [7:0] acc;
    logic [2:0] st;
    logic [7:0] lit;
    logic [7:0] res;
    logic [2:0] fl;
  } srrse_row_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] pc_out;
  logic        power_down_flag_n;
  logic        watchdog_expiry_flag_n;
  int          n_mismatch;
  int          total_checks;
  logic [31:0] q;
  logic [31:0] s;
  logic        e;
  logic [11:0] fad;
  logic        to_file;
  srrse_row_t  r;
  srrse_row_t  rows [9];

  srrse_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pc_out(pc_out), .power_down_flag_n(power_down_flag_n), .watchdog_expiry_flag_n(watchdog_expiry_flag_n));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One transfer; pready, data and error are taken as the edge sees them
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int   n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge pclk);
      rdy = pready;
      q = prdata;
      e = pslverr;
      n++;
    end
    if (rdy !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    n_mismatch = 0;
    total_checks = 0;
    rows = '{'{3'h1, 1'b1, 7'h00, 8'h02, 8'h33, 3'h7, 8'h00, 8'h81, 3'h6},
             '{3'h1, 1'b0, 7'h7f, 8'h81, 8'h55, 3'h0, 8'h00, 8'h40, 3'h1},
             '{3'h2, 1'b0, 7'h05, 8'h10, 8'h01, 3'h0, 8'h00, 8'h0f, 3'h1},
             '{3'h2, 1'b1, 7'h06, 8'h05, 8'h05, 3'h6, 8'h00, 8'h00, 3'h7},
             '{3'h2, 1'b0, 7'h07, 8'h02, 8'h03, 3'h7, 8'h00, 8'hff, 3'h0},
             '{3'h3, 1'b0, 7'h08, 8'h01, 8'h01, 3'h0, 8'h00, 8'hff, 3'h0},
             '{3'h3, 1'b1, 7'h09, 8'h01, 8'h01, 3'h1, 8'h00, 8'h00, 3'h7},
             '{3'h4, 1'b1, 7'h0a, 8'h3c, 8'h00, 3'h0, 8'hff, 8'hff, 3'h3},
             '{3'h4, 1'b0, 7'h0b, 8'h3c, 8'h01, 3'h7, 8'h00, 8'hff, 3'h0}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status_rst", q, 32'h18);
    foreach (rows[i]) begin
      r = rows[i];
      fad = OFS_FILE_BASE + {3'h0, r.fa, 2'h0};
      to_file = r.d && (r.op != SRRSE_OP_SUBLIT);
      apb(1'b1, fad, {24'h0, r.fv});
      apb(1'b1, OFS_ACC, {24'h0, r.acc});
      apb(1'b1, OFS_STATUS, {29'h0, r.st});
      apb(1'b1, OFS_INSTR, {8'h00, r.lit, 5'h00, r.fa, r.d, r.op});
      apb(1'b0, OFS_ACC, 32'h0);
      chk("acc", q, {24'h0, to_file ? r.acc : r.res});
      apb(1'b0, fad, 32'h0);
      chk("file", q, {24'h0, to_file ? r.res : r.fv});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("flags", {29'h0, q[2:0]}, {29'h0, r.fl});
    end
    // Return after a push, flags preset to a known pattern
    apb(1'b1, OFS_STATUS, 32'h5);
    apb(1'b1, OFS_PC, 32'h1234);
    apb(1'b1, OFS_INSTR, {29'h0, SRRSE_OP_PUSH});
    apb(1'b1, OFS_PC, 32'h0055);
    apb(1'b1, OFS_INSTR, {29'h0, SRRSE_OP_RETURN});
    apb(1'b0, OFS_STACK, 32'h0);
    s = q;
    chk("ret_pc", {17'h0, pc_out}, 32'h1234);
    chk("ret_head", {17'h0, s[14:0]}, 32'h1234);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("ret_flags", {27'h0, q[4:0]}, 32'h1d);
    apb(1'b1, OFS_INSTR, {29'h0, SRRSE_OP_NOP});
    chk("ret_next", {17'h0, pc_out}, 32'h1235);
    // Sleep after the watchdog has counted
    repeat (600) @(posedge pclk);
    apb(1'b0, OFS_WDOG, 32'h0);
    chk("wdog_run", {31'h0, q[7:0] != 8'h00}, 32'h1);
    apb(1'b1, OFS_INSTR, {29'h0, SRRSE_OP_SLEEP});
    chk("pd_n", {31'h0, power_down_flag_n}, 32'h0);
    chk("to_n", {31'h0, watchdog_expiry_flag_n}, 32'h1);
    apb(1'b0, OFS_WDOG, 32'h0);
    chk("wdog", {24'h0, q[7:0]}, 32'h0);
    chk("presc", {31'h0, q[15:8] <= 8'h03}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_data", q, 32'h0);
    // Reset in mid-run restores the flags and pc
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pd_rst", {31'h0, power_down_flag_n}, 32'h1);
    chk("pc_rst", {17'h0, pc_out}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status_rst2", q, 32'h18);
    finish_test();
  end
endmodule // subtract_rotate_return_sleep_exec_test
